// ===== verilog/tpdc_pkg.sv
// Purpose: Shared constants and types for the dual PWM and capture timer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Mode codes and the interrupt source encodings are local choices.
package tpdc_pkg;
   localparam logic [15:0] TPDC_RELOAD_START = 16'h0001;
   localparam logic [15:0] TPDC_COUNT_RESET  = 16'h0000;
   localparam logic [7:0]  TPDC_DEAD_MAX     = 8'h80;
   localparam logic [7:0]  TPDC_PRESCALE_RST = 8'h00;

   typedef enum logic [1:0] {
      TPDC_MODE_PWM_SINGLE,
      TPDC_MODE_PWM_DUAL,
      TPDC_MODE_CAPTURE,
      TPDC_MODE_IDLE
   } tpdc_mode_type;

   typedef enum logic [1:0] {
      TPDC_IRQ_BOTH,
      TPDC_IRQ_BOTH_ALT,
      TPDC_IRQ_CAPTURE_ONLY,
      TPDC_IRQ_RELOAD_ONLY
   } tpdc_isrc_type;

   typedef struct packed {
      logic          enable;
      logic [1:0]    mode_field;
      logic          mode_select_upper_bit;
      logic          output_polarity_edge_select;
      logic [2:0]    prescale_sel;
      tpdc_isrc_type interrupt_source_config;
      logic [7:0]    deadband;
   } tpdc_ctrl_type;

   typedef struct packed {
      logic        load;
      logic [15:0] value;
   } tpdc_load_type;
endpackage : tpdc_pkg

// ===== verilog/tpdc_timer.sv
// Purpose: 16-bit up timer with single and dual PWM output and input capture.
// Assumes: Settings change only while the timer is disabled.
// Notes: Prescale is 2 to the power of the prescale select.
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// RULE1: PWM counts up, toggles output at match.
// RULE2: PWM reload raises interrupt, count restarts 0001h.
// RULE3: Polarity one starts high, low at match.
// RULE4: Polarity zero starts low, high at match.
// RULE5: Software start count used only first pass.
// RULE6: Software keeps reload above PWM match value.
// RULE7: Counter advances on prescaled system clock.
// RULE8: Dual mode drives complement of primary output.
// RULE9: Dual mode delays rising edges by deadband.
// RULE10: Software keeps deadband shorter than both phases.
// RULE11: Dual mode needs mode field and upper bit.
// RULE12: Dual mode turns input pin into complement.
// RULE13: Capture copies count into PWM registers.
// RULE14: Capture raises interrupt, counter keeps running.
// RULE15: Capture interrupt sets capture event flag.
// RULE16: Capture reload raises interrupt without count reset.
// RULE17: Capture reload interrupt clears capture event flag.
// RULE18: Source config limits capture interrupt sources.
// RULE19: Software clears PWM registers before capture.
// RULE20: Software disables timer before changing settings.
// RULE21: Capture counter wraps from all ones to zero.
module tpdc_timer (
   // Clock and reset.
   input  wire logic                    CLK,
   input  wire logic                    RST,
   // Configuration.
   input  wire tpdc_pkg::tpdc_ctrl_type CTRL,
   input  wire tpdc_pkg::tpdc_load_type COUNT_LOAD,
   input  wire tpdc_pkg::tpdc_load_type PWM_LOAD,
   input  wire logic [15:0]             RELOAD,
   // Status.
   output logic [15:0]                  COUNT,
   output logic [15:0]                  PWM_VALUE,
   output logic                         CAPTURE_EVENT_FLAG,
   output logic                         IRQ,
   // Pins.
   input  wire logic                    TIMER_IN_PIN,
   output logic                         TIMER_OUT,
   output logic                         TIMER_OUT_OE,
   output logic                         TIMER_OUT_N,
   output logic                         TIMER_OUT_N_OE
);
   import tpdc_pkg::*;

   logic [1:0]  in_sync;
   logic        in_prev;
   logic [7:0]  pre_cnt;
   logic [15:0] count;
   logic [15:0] pwm_value;
   logic        pwm_level;
   logic        cap_flag;
   logic        irq;
   logic [7:0]  dead_p;
   logic [7:0]  dead_n;
   logic        out_p;
   logic        out_n;
   logic [7:0]  next_pre_cnt;
   logic [15:0] next_count;
   logic [15:0] next_pwm_value;
   logic        next_pwm_level;
   logic        next_cap_flag;
   logic        next_irq;
   logic [7:0]  next_dead_p;
   logic [7:0]  next_dead_n;
   logic        next_out_p;
   logic        next_out_n;

   tpdc_mode_type mode;
   logic          tick;
   logic          in_edge;
   logic          pwm_mode;
   logic          dual;

   function automatic tpdc_mode_type decode_mode(input logic [1:0] f, input logic hi);
      if (f == 2'b11 && hi) begin
         decode_mode = TPDC_MODE_PWM_DUAL;
      end else if (f == 2'b11) begin
         decode_mode = TPDC_MODE_PWM_SINGLE;
      end else if (f == 2'b01) begin
         decode_mode = TPDC_MODE_CAPTURE;
      end else begin
         decode_mode = TPDC_MODE_IDLE;
      end
   endfunction : decode_mode

   // Deadband step: hold low until the delay expires, drop at once.
   function automatic logic [8:0] dead_step(input logic want, input logic cur,
                                            input logic [7:0] cnt, input logic [7:0] dly);
      if (!want) begin
         dead_step = {1'b0, 8'h00};
      end else if (cur) begin
         dead_step = {1'b1, cnt};
      end else if (cnt >= dly) begin
         dead_step = {1'b1, 8'h00};
      end else begin
         dead_step = {1'b0, cnt + 8'h01};
      end
   endfunction : dead_step

   // RULE11: mode from both fields.
   assign mode     = decode_mode(CTRL.mode_field, CTRL.mode_select_upper_bit);
   assign pwm_mode = (mode == TPDC_MODE_PWM_SINGLE) || (mode == TPDC_MODE_PWM_DUAL);
   assign dual     = (mode == TPDC_MODE_PWM_DUAL);
   // RULE7: prescaled counting tick.
   assign tick     = CTRL.enable &&
                     ((pre_cnt & ((8'h01 << CTRL.prescale_sel) - 8'h01)) ==
                      ((8'h01 << CTRL.prescale_sel) - 8'h01));
   // RULE13: edge chosen by polarity.
   assign in_edge  = CTRL.output_polarity_edge_select ? (in_sync[1] && !in_prev)
                                                      : (!in_sync[1] && in_prev);

   always_comb begin
      logic [8:0] sp;
      logic [8:0] sn;
      sp = 9'h000;
      sn = 9'h000;
      next_pre_cnt   = CTRL.enable ? pre_cnt + 8'h01 : TPDC_PRESCALE_RST;
      next_count     = count;
      next_pwm_value = pwm_value;
      next_pwm_level = pwm_level;
      next_cap_flag  = cap_flag;
      next_irq       = 1'b0;
      if (COUNT_LOAD.load) begin
         next_count = COUNT_LOAD.value;
      end
      if (PWM_LOAD.load) begin
         next_pwm_value = PWM_LOAD.value;
      end
      if (!CTRL.enable) begin
         // RULE3: idle level follows polarity.
         // RULE4: idle level follows polarity.
         next_pwm_level = CTRL.output_polarity_edge_select;
      end else if (pwm_mode && tick) begin
         if (count == RELOAD) begin
            // RULE2: reload restarts at 0001h.
            // RULE5: later passes start at 0001h.
            next_count     = TPDC_RELOAD_START;
            next_irq       = 1'b1;
            next_pwm_level = CTRL.output_polarity_edge_select;
         end else begin
            next_count = count + 16'h0001;
            // RULE1: toggle on match.
            if (count == pwm_value) begin
               next_pwm_level = !pwm_level;
            end
         end
      end else if (mode == TPDC_MODE_CAPTURE) begin
         if (tick) begin
            // RULE21: natural 16-bit wrap.
            next_count = count + 16'h0001;
         end
         if (in_edge) begin
            // RULE13: capture the count.
            // RULE14: no counter reset.
            // RULE15: set capture flag.
            next_pwm_value = count;
            next_cap_flag  = 1'b1;
            next_irq       = (CTRL.interrupt_source_config != TPDC_IRQ_RELOAD_ONLY);
         end else if (tick && count == RELOAD) begin
            // RULE16: reload interrupt, no reset.
            // RULE17: clear capture flag.
            // RULE18: source filter.
            next_cap_flag = 1'b0;
            next_irq      = (CTRL.interrupt_source_config != TPDC_IRQ_CAPTURE_ONLY);
         end
      end
      // RULE8: complement in dual mode.
      // RULE9: delayed rising edges.
      sp = dead_step(next_pwm_level, out_p, dead_p, CTRL.deadband);
      sn = dead_step(!next_pwm_level && dual, out_n, dead_n, CTRL.deadband);
      next_out_p  = dual ? sp[8] : next_pwm_level;
      next_dead_p = dual ? sp[7:0] : 8'h00;
      next_out_n  = sn[8];
      next_dead_n = sn[7:0];
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         in_sync   <= 2'b00;
         in_prev   <= 1'b0;
         pre_cnt   <= TPDC_PRESCALE_RST;
         count     <= TPDC_COUNT_RESET;
         pwm_value <= TPDC_COUNT_RESET;
         pwm_level <= 1'b0;
         cap_flag  <= 1'b0;
         irq       <= 1'b0;
         dead_p    <= 8'h00;
         dead_n    <= 8'h00;
         out_p     <= 1'b0;
         out_n     <= 1'b0;
      end else begin
         in_sync   <= {in_sync[0], TIMER_IN_PIN};
         in_prev   <= in_sync[1];
         pre_cnt   <= next_pre_cnt;
         count     <= next_count;
         pwm_value <= next_pwm_value;
         pwm_level <= next_pwm_level;
         cap_flag  <= next_cap_flag;
         irq       <= next_irq;
         dead_p    <= next_dead_p;
         dead_n    <= next_dead_n;
         out_p     <= next_out_p;
         out_n     <= next_out_n;
      end
   end

   assign COUNT              = count;
   assign PWM_VALUE          = pwm_value;
   assign CAPTURE_EVENT_FLAG = cap_flag;
   assign IRQ                = irq;
   assign TIMER_OUT          = out_p;
   assign TIMER_OUT_OE       = pwm_mode;
   assign TIMER_OUT_N        = out_n;
   // RULE12: pin becomes complement output.
   assign TIMER_OUT_N_OE     = dual;

   // RULE2: reload restarts count.
   reload_restart_a: assert property (@(posedge CLK) disable iff (RST) // RULE2
      (CTRL.enable && pwm_mode && tick && count == RELOAD && !COUNT_LOAD.load)
      |=> (count == TPDC_RELOAD_START) && irq)
      else $error("PWM reload did not restart at one.");
   // RULE1: match toggles level.
   match_toggle_a: assert property (@(posedge CLK) disable iff (RST) // RULE1
      (CTRL.enable && pwm_mode && tick && count == pwm_value && count != RELOAD)
      |=> pwm_level != $past(pwm_level))
      else $error("PWM level did not toggle at match.");
   // RULE3: reload level polarity.
   reload_level_a: assert property (@(posedge CLK) disable iff (RST) // RULE3
      (CTRL.enable && pwm_mode && tick && count == RELOAD)
      |=> pwm_level == $past(CTRL.output_polarity_edge_select))
      else $error("PWM level wrong after reload.");
   // RULE4: disabled level polarity.
   idle_level_a: assert property (@(posedge CLK) disable iff (RST) // RULE4
      !CTRL.enable |=> pwm_level == $past(CTRL.output_polarity_edge_select))
      else $error("Idle level does not follow polarity.");
   // RULE8: outputs never both high.
   no_overlap_a: assert property (@(posedge CLK) disable iff (RST) // RULE8
      dual |-> !(out_p && out_n))
      else $error("Both dual outputs high.");
   // RULE9: falling edge immediate.
   fall_fast_a: assert property (@(posedge CLK) disable iff (RST) // RULE9
      (dual && out_p && !next_pwm_level) |=> !out_p)
      else $error("Falling edge was delayed.");
   // RULE13: capture stores count.
   capture_store_a: assert property (@(posedge CLK) disable iff (RST) // RULE13
      (CTRL.enable && mode == TPDC_MODE_CAPTURE && in_edge && !PWM_LOAD.load)
      |=> pwm_value == $past(count) && cap_flag)
      else $error("Capture did not store the count.");
   // RULE16: capture reload no reset.
   cap_reload_a: assert property (@(posedge CLK) disable iff (RST) // RULE16
      (mode == TPDC_MODE_CAPTURE && tick && !in_edge && count == RELOAD && !COUNT_LOAD.load)
      |=> count == $past(count) + 16'h0001 && !cap_flag)
      else $error("Capture reload reset the count.");
endmodule : tpdc_timer

`default_nettype wire

// ===== bench/tpdc_load_model.sv
// Purpose: Load and power stage model on the timer pins.
// Assumes: The bench sets the level that the stage drives on the input pin.
// Notes: Counts cycles where both outputs are high at once.
`timescale 1ns/1ps
`default_nettype none
module tpdc_load_model (
   // Clock.
   input  wire logic CLK,
   // Stage side.
   input  wire logic DRIVE_LEVEL,
   output var  int   OVERLAP,
   // Timer pins.
   input  wire logic TIMER_OUT,
   input  wire logic TIMER_OUT_N,
   input  wire logic TIMER_OUT_N_OE,
   output logic      PIN
);
   assign PIN = TIMER_OUT_N_OE ? TIMER_OUT_N : DRIVE_LEVEL;
   initial OVERLAP = 0;
   always @(posedge CLK) begin
      if (TIMER_OUT === 1'b1 && TIMER_OUT_N === 1'b1) begin
         OVERLAP <= OVERLAP + 1;
      end
   end
endmodule : tpdc_load_model
`default_nettype wire

// ===== bench/tpdc_timer_bench.sv
// Purpose: Self-checking bench for the PWM and capture timer.
// Assumes: Settings change only while the timer is disabled.
// Notes: The input pin is driven through the load model.
`timescale 1ns/1ps
`default_nettype none
module tpdc_timer_bench;
   import tpdc_pkg::*;
   logic          clk, rst, flag, irq, pin, drive, t_out, t_oe, t_n, t_n_oe;
   tpdc_ctrl_type ctrl;
   tpdc_load_type cnt_ld, pwm_ld;
   logic [15:0]   reload, count, pwm_value;
   int            overlap, n_irq, n_mismatch, samples_checked;

   tpdc_timer dut_u (.CLK(clk), .RST(rst), .CTRL(ctrl), .COUNT_LOAD(cnt_ld),
      .PWM_LOAD(pwm_ld), .RELOAD(reload), .COUNT(count), .PWM_VALUE(pwm_value),
      .CAPTURE_EVENT_FLAG(flag), .IRQ(irq), .TIMER_IN_PIN(pin), .TIMER_OUT(t_out),
      .TIMER_OUT_OE(t_oe), .TIMER_OUT_N(t_n), .TIMER_OUT_N_OE(t_n_oe));
   tpdc_load_model load_u (.CLK(clk), .DRIVE_LEVEL(drive), .OVERLAP(overlap),
      .TIMER_OUT(t_out), .TIMER_OUT_N(t_n), .TIMER_OUT_N_OE(t_n_oe), .PIN(pin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq === 1'b1) begin
         n_irq <= n_irq + 1;
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic setup(input logic [1:0] mf, input logic up, input logic pol,
      input logic [2:0] sel, input tpdc_isrc_type src, input logic [7:0] dead,
      input logic [15:0] c, input logic [15:0] p, input logic [15:0] r);
      @(negedge clk);
      ctrl.enable = 1'b0;
      @(negedge clk);
      ctrl = '{1'b0, mf, up, pol, sel, src, dead};
      cnt_ld = '{1'b1, c};
      pwm_ld = '{1'b1, p};
      reload = r;
      @(negedge clk);
      cnt_ld.load = 1'b0;
      pwm_ld.load = 1'b0;
      ctrl.enable = 1'b1;
      n_irq = 0;
   endtask : setup

   task automatic hi_time(input int n, output int a, output int b);
      a = 0;
      b = 0;
      repeat (n) begin
         @(negedge clk);
         a += int'(t_out);
         b += int'(t_n);
      end
   endtask : hi_time

   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== 1'b1 && n < 40);
      if (irq !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
   endtask : wait_irq

   task automatic t_pwm();
      int a, b;
      for (int i = 0; i < 3; i++) begin
         setup(2'b11, 1'b0, i[0], {2'b00, i[1]}, TPDC_IRQ_BOTH, 8'h00, 16'h0001,
            16'h0003, 16'h0008);
         repeat (16) @(negedge clk);
         n_irq = 0;
         hi_time(64, a, b);
         chk(16'(a), i[0] ? 16'h0018 : 16'h0028);
         chk(16'(n_irq), i[1] ? 16'h0004 : 16'h0008);
         chk({14'h0000, t_oe, t_n_oe}, 16'h0002);
      end
   endtask : t_pwm

   task automatic t_start();
      int n;
      setup(2'b11, 1'b0, 1'b0, 3'd0, TPDC_IRQ_BOTH, 8'h00, 16'h0006, 16'h0003, 16'h0008);
      wait_irq(n);
      chk(16'(n), 16'h0003);
      chk(count, TPDC_RELOAD_START);
      wait_irq(n);
      chk(16'(n), 16'h0008);
   endtask : t_start

   task automatic t_dual();
      int a, b, o;
      for (int d = 0; d < 3; d += 2) begin
         setup(2'b11, 1'b1, 1'b0, 3'd0, TPDC_IRQ_BOTH, 8'(d), 16'h0001, 16'h0003,
            16'h0008);
         repeat (16) @(negedge clk);
         o = overlap;
         hi_time(64, a, b);
         chk(16'(a), 16'(40 - 8 * d));
         chk(16'(b), 16'(24 - 8 * d));
         chk(16'(overlap - o), 16'h0000);
         chk({14'h0000, t_oe, t_n_oe}, 16'h0003);
      end
   endtask : t_dual

   task automatic t_cap();
      tpdc_isrc_type src [3] = '{TPDC_IRQ_BOTH, TPDC_IRQ_CAPTURE_ONLY, TPDC_IRQ_RELOAD_ONLY};
      logic [15:0] c;
      @(negedge clk);
      ctrl.enable = 1'b0;
      @(negedge clk);
      ctrl.mode_select_upper_bit = 1'b0;
      drive = 1'b0;
      repeat (4) @(negedge clk);
      chk({15'h0000, t_n_oe}, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         drive = 1'b0;
         setup(2'b01, 1'b0, i[0], 3'd0, src[i], 8'h00, 16'hFFFE, 16'h0000, 16'h0005);
         repeat (12) @(negedge clk);
         chk({15'h0000, count > 16'h0005 && count < 16'h0010}, 16'h0001);
         chk({15'h0000, flag}, 16'h0000);
         chk(pwm_value, 16'h0000);
         c = count;
         drive = 1'b1;
         repeat (8) @(negedge clk);
         drive = 1'b0;
         repeat (8) @(negedge clk);
         chk({15'h0000, flag}, 16'h0001);
         chk({15'h0000, pwm_value > c && pwm_value < c + 16'h0012}, 16'h0001);
         chk({15'h0000, count > pwm_value}, 16'h0001);
         chk(16'(n_irq), i == 0 ? 16'h0002 : 16'h0001);
      end
   endtask : t_cap

   initial begin
      rst = 1'b1;
      ctrl = '0;
      cnt_ld = '0;
      pwm_ld = '0;
      reload = 16'h0000;
      drive = 1'b0;
      n_irq = 0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk(count, TPDC_COUNT_RESET);
      t_pwm();
      t_start();
      t_dual();
      t_cap();
      test_done();
   end
endmodule : tpdc_timer_bench
`default_nettype wire
